// [verilog/bus_target_permission_log_defines.vh]
// constants for the bus target permission and violation log block
`ifndef BUS_TARGET_PERMISSION_LOG_DEFINES_VH
`define BUS_TARGET_PERMISSION_LOG_DEFINES_VH

// ************************************************************
// sizes
// ************************************************************
`define NUM_TARGETS        14
`define NUM_REGIONS        9
`define NUM_ENTRIES        126
`define LAST_TARGET        4'hd
`define LAST_REGION        4'h8

// ************************************************************
// register map, byte addresses and upper address page fields
// ************************************************************
`define ADDR_LOG_PAGE      6'h00
`define ADDR_STATUS        12'h040
`define ADDR_MASK          12'h044
`define ADDR_PERM_PAGE     2'h1

// ************************************************************
// error log layout
// ************************************************************
`define LOG_MULTI_BIT      31
`define LOG_CODE_MSB       27
`define LOG_CODE_LSB       24
`define LOG_ID_MSB         15
`define LOG_ID_LSB         8
`define LOG_REGION_MSB     7
`define LOG_REGION_LSB     4
`define LOG_CMD_MSB        2
`define LOG_CMD_LSB        0
`define CODE_NONE          4'h0
`define CODE_PERMISSION    4'h3

// ************************************************************
// write permission layout
// ************************************************************
`define PERM_RESET         4'h7
`define PERM_RO_REGION     4'h0
`define PERM_RO_MASK       4'h1

`endif

// [verilog/permission_table.v]
// write permission storage for every target and region
`include "bus_target_permission_log_defines.vh"

module permission_table (
  input  wire       clk,
  input  wire       nrst,
  input  wire       wr_en,
  input  wire [6:0] wr_idx,
  input  wire [3:0] wr_data,
  input  wire [3:0] wr_ro_mask,
  input  wire [6:0] rd_idx_a,
  output wire [3:0] rd_data_a,
  input  wire [6:0] rd_idx_b,
  output wire [3:0] rd_data_b
);

  reg [3:0] mem_reg [0:`NUM_ENTRIES-1];
  integer   i;

  assign rd_data_a = mem_reg[rd_idx_a];
  assign rd_data_b = mem_reg[rd_idx_b];

  // ************************************************************
  // storage
  // ************************************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < `NUM_ENTRIES; i = i + 1) begin
        mem_reg[i] <= `PERM_RESET;
      end
    end else if (wr_en) begin
      mem_reg[wr_idx] <= (wr_data & ~wr_ro_mask) | (mem_reg[wr_idx] & wr_ro_mask);
    end
  end

endmodule // permission_table

// [verilog/violation_log.v]
// error log of one bus target
`include "bus_target_permission_log_defines.vh"

module violation_log (
  input  wire        clk,
  input  wire        nrst,
  input  wire        viol,
  input  wire [7:0]  viol_id,
  input  wire [3:0]  viol_region,
  input  wire [2:0]  viol_cmd,
  input  wire        clr_en,
  input  wire [31:0] clr_data,
  output wire [31:0] log_word
);

  reg        multi_reg;
  reg  [3:0] code_reg;
  reg  [7:0] id_reg;
  reg  [3:0] region_reg;
  reg  [2:0] cmd_reg;
  wire [3:0] code_kept;
  wire       capture;

  assign code_kept = clr_en ? (code_reg & ~clr_data[`LOG_CODE_MSB:`LOG_CODE_LSB]) : code_reg;
  assign capture   = viol && (code_kept == `CODE_NONE);

  assign log_word = {multi_reg, 3'h0, code_reg, 8'h00, id_reg, region_reg, 1'b0, cmd_reg};

  // ************************************************************
  // log state
  // ************************************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      multi_reg  <= 1'b0;
      code_reg   <= `CODE_NONE;
      id_reg     <= 8'h00;
      region_reg <= 4'h0;
      cmd_reg    <= 3'h0;
    end else begin
      if (viol && !capture) begin
        multi_reg <= 1'b1;
      end else if (clr_en && clr_data[`LOG_MULTI_BIT]) begin
        multi_reg <= 1'b0;
      end
      code_reg <= viol ? `CODE_PERMISSION : code_kept;
      if (capture) begin
        id_reg     <= viol_id;
        region_reg <= viol_region;
        cmd_reg    <= viol_cmd;
      end
    end
  end

endmodule // violation_log

// [verilog/bus_target_permission_log.v]
// system bus target write protection with violation logs and apb registers
//
// Overview of operation
// - A second violation while a log is busy sets its multiple flag, cleared by writing one.
// - The four-bit fault code reads 0011 after a permission violation and 0000 otherwise.
// - Writing ones onto the fault code bits returns the code to no error.
// - Each of targets 0 to 13 has a log of initiator, region and command, read-only, reset zero.
// - Each target has nine region permission registers whose bit n lets group n write.
// - A group 3 write to a region whose group 3 bit is clear is denied and logged.
// - Some permission bits of certain regions are preset and ignore writes.
// - Permission bits 31 to 4 read zero and ignore writes.
`include "bus_target_permission_log_defines.vh"

module bus_target_permission_log (
  input  wire        CLK,
  input  wire        NRST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        ACC_VALID,
  input  wire        ACC_WRITE,
  input  wire [3:0]  ACC_TARGET,
  input  wire [3:0]  ACC_REGION,
  input  wire [1:0]  ACC_GROUP,
  input  wire [7:0]  ACC_ID,
  input  wire [2:0]  ACC_CMD,
  output wire        ACC_GRANT,
  output wire        ACC_DENY,
  output wire        IRQ
);

  // ************************************************************
  // declarations
  // ************************************************************
  reg  [31:0] prdata_reg;
  reg  [31:0] prdata_next;
  reg         pready_reg;
  reg         pslverr_reg;
  reg         pslverr_next;
  reg         grant_reg;
  reg         deny_reg;
  reg         irq_reg;
  reg  [13:0] status_reg;
  reg  [13:0] status_next;
  reg  [13:0] mask_reg;

  wire        apb_setup;
  wire        apb_commit;
  wire        apb_wr;
  wire        apb_rd;
  wire        is_log;
  wire        is_perm;
  wire        is_status;
  wire        is_mask;
  wire [3:0]  bus_target;
  wire [3:0]  bus_region;
  wire [6:0]  bus_idx;
  wire [3:0]  bus_perm;
  wire [3:0]  bus_ro;

  wire        acc_in_range;
  wire [6:0]  acc_idx;
  wire [3:0]  acc_perm;
  wire        acc_allowed;
  wire        acc_viol;
  wire [13:0] viol_vec;
  wire [31:0] acc_target_wide;
  wire [31:0] log_sel_wide;

  wire [31:0] log_word [0:`NUM_TARGETS-1];

  // ************************************************************
  // apb decode
  // ************************************************************
  // data captured in setup so that pready and prdata both come from flops
  assign apb_setup  = PSEL && !PENABLE;
  assign apb_commit = PSEL && PENABLE && pready_reg;
  assign apb_wr     = apb_commit && PWRITE && !pslverr_reg;
  assign apb_rd     = apb_commit && !PWRITE && !pslverr_reg;

  assign bus_target = PADDR[9:6];
  assign bus_region = PADDR[5:2];
  assign is_log     = (PADDR[11:6] == `ADDR_LOG_PAGE) && (PADDR[5:2] <= `LAST_TARGET)
                      && (PADDR[1:0] == 2'h0);
  assign is_status  = (PADDR == `ADDR_STATUS);
  assign is_mask    = (PADDR == `ADDR_MASK);
  assign is_perm    = (PADDR[11:10] == `ADDR_PERM_PAGE) && (bus_target <= `LAST_TARGET)
                      && (bus_region <= `LAST_REGION) && (PADDR[1:0] == 2'h0);

  // index is target times nine plus region
  assign bus_idx = {bus_target, 3'h0} + {3'h0, bus_target} + {3'h0, bus_region};
  assign bus_ro  = (bus_region == `PERM_RO_REGION) ? `PERM_RO_MASK : 4'h0;

  // ************************************************************
  // permission storage
  // ************************************************************
  permission_table u_table (
    .clk        (CLK),
    .nrst       (NRST),
    .wr_en      (apb_wr && is_perm),
    .wr_idx     (bus_idx),
    .wr_data    (PWDATA[3:0]),
    .wr_ro_mask (bus_ro),
    .rd_idx_a   (bus_idx),
    .rd_data_a  (bus_perm),
    .rd_idx_b   (acc_idx),
    .rd_data_b  (acc_perm)
  );

  // ************************************************************
  // access check
  // ************************************************************
  // accesses outside the map carry no permission record and pass
  assign acc_in_range = (ACC_TARGET <= `LAST_TARGET) && (ACC_REGION <= `LAST_REGION);
  assign acc_idx      = {ACC_TARGET, 3'h0} + {3'h0, ACC_TARGET} + {3'h0, ACC_REGION};
  assign acc_allowed  = !acc_in_range || !ACC_WRITE || acc_perm[ACC_GROUP];
  assign acc_viol     = ACC_VALID && !acc_allowed;

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      grant_reg <= 1'b0;
      deny_reg  <= 1'b0;
    end else begin
      grant_reg <= ACC_VALID && acc_allowed;
      deny_reg  <= acc_viol;
    end
  end

  // ************************************************************
  // per target logs
  // ************************************************************
  // widened so the compare against the loop index drops no bits
  assign acc_target_wide = {28'h0000000, ACC_TARGET};
  assign log_sel_wide    = {28'h0000000, PADDR[5:2]};

  genvar g;
  generate
    for (g = 0; g < `NUM_TARGETS; g = g + 1) begin : g_log
      assign viol_vec[g] = acc_viol && (acc_target_wide == g);
      violation_log u_log (
        .clk         (CLK),
        .nrst        (NRST),
        .viol        (viol_vec[g]),
        .viol_id     (ACC_ID),
        .viol_region (ACC_REGION),
        .viol_cmd    (ACC_CMD),
        .clr_en      (apb_wr && is_log && (log_sel_wide == g)),
        .clr_data    (PWDATA),
        .log_word    (log_word[g])
      );
    end
  endgenerate

  // ************************************************************
  // interrupt status
  // ************************************************************
  always @* begin
    status_next = status_reg;
    // read clears only the bits it reported, so an event after the setup edge is kept
    if (apb_rd && is_status) begin
      status_next = status_reg & ~prdata_reg[13:0];
    end
    status_next = status_next | viol_vec;
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      status_reg <= 14'h0000;
      mask_reg   <= 14'h0000;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (apb_wr && is_mask) begin
        mask_reg <= PWDATA[13:0];
      end
      irq_reg <= |(status_next & (apb_wr && is_mask ? PWDATA[13:0] : mask_reg));
    end
  end

  // ************************************************************
  // apb read data and answer
  // ************************************************************
  always @* begin
    prdata_next  = 32'h00000000;
    pslverr_next = 1'b0;
    if (is_log) begin
      prdata_next = log_word[PADDR[5:2]];
    end else if (is_perm) begin
      prdata_next = {28'h0000000, bus_perm};
    end else if (is_status) begin
      prdata_next = {18'h00000, status_reg};
    end else if (is_mask) begin
      prdata_next = {18'h00000, mask_reg};
    end else begin
      pslverr_next = 1'b1;
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_setup;
      if (apb_setup) begin
        prdata_reg  <= PWRITE ? 32'h00000000 : prdata_next;
        pslverr_reg <= pslverr_next;
      end else if (apb_commit || !PSEL) begin
        prdata_reg  <= 32'h00000000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign PRDATA    = prdata_reg;
  assign PREADY    = pready_reg;
  assign PSLVERR   = pslverr_reg;
  assign ACC_GRANT = grant_reg;
  assign ACC_DENY  = deny_reg;
  assign IRQ       = irq_reg;

endmodule // bus_target_permission_log

// [verification/bus_target_permission_log_monitor.sv]
// assertion checker for the bus target permission log block
module bus_target_permission_log_monitor (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        ACC_VALID,
  input wire logic        ACC_WRITE,
  input wire logic [3:0]  ACC_TARGET,
  input wire logic        ACC_GRANT,
  input wire logic        ACC_DENY,
  input wire logic        IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ********************
  // apb and access checks
  // ********************
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence ack_s; PREADY ##1 !PREADY; endsequence
  wire rd_perm = PREADY && !PWRITE && PADDR[11:10] == 2'h1;
  wire rd_reg0 = rd_perm && PADDR[5:0] == 6'h0 && PADDR[9:6] <= 4'hd;
  wire rd_log  = PREADY && !PWRITE && PADDR < 12'h038;
  wire log_gap = (|PRDATA[30:28]) || (|PRDATA[23:16]) || PRDATA[3];
  ready_once_a: assert property (setup_s |=> ack_s)
    else $error("pready not one cycle after setup");
  one_answer_a: assert property (ACC_VALID |=> ACC_GRANT ^ ACC_DENY)
    else $error("access not answered once");
  read_grant_a: assert property (ACC_VALID && !ACC_WRITE |=> ACC_GRANT)
    else $error("read access not granted");
  range_grant_a: assert property (ACC_VALID && ACC_TARGET > 4'hd |=> ACC_GRANT)
    else $error("far target not granted");
  perm_upper_a: assert property (rd_perm |-> PRDATA[31:4] == 28'h0)
    else $error("permission upper bits set");
  fixed_bit_a: assert property (rd_reg0 |-> PRDATA[0])
    else $error("preset bit not one");
  log_unused_a: assert property (rd_log |-> !log_gap)
    else $error("log unused bits set");
  irq_cause_a: assert property ($rose(IRQ) |-> ACC_DENY || $past(PSEL && PWRITE))
    else $error("irq rose without cause");
endmodule // bus_target_permission_log_monitor

bind bus_target_permission_log bus_target_permission_log_monitor mon_u (.CLK, .NRST, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .ACC_VALID, .ACC_WRITE, .ACC_TARGET,
  .ACC_GRANT, .ACC_DENY, .IRQ);

// [verification/bus_initiator_model.sv]
// behavioural bus initiator issuing accesses to protected targets
module bus_initiator_model (
  input  wire logic       CLK,
  output logic            ACC_VALID,
  output logic            ACC_WRITE,
  output logic [3:0]      ACC_TARGET,
  output logic [3:0]      ACC_REGION,
  output logic [1:0]      ACC_GROUP,
  output logic [7:0]      ACC_ID,
  output logic [2:0]      ACC_CMD,
  input  wire logic       ACC_GRANT,
  input  wire logic       ACC_DENY
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ACC_VALID, ACC_WRITE, ACC_TARGET, ACC_REGION, ACC_GROUP, ACC_ID, ACC_CMD} = '0;
  // one access; fields are inverted on release so stale values never pass for live ones
  task automatic access(input logic w, input logic [3:0] t, r, input logic [1:0] g,
    input logic [7:0] id, input logic [2:0] c, output logic gr, dn);
    @(posedge CLK);
    {ACC_VALID, ACC_WRITE, ACC_TARGET, ACC_REGION, ACC_GROUP, ACC_ID, ACC_CMD}
      <= {1'b1, w, t, r, g, id, c};
    @(posedge CLK);
    {ACC_VALID, ACC_WRITE, ACC_TARGET, ACC_REGION, ACC_GROUP, ACC_ID, ACC_CMD}
      <= {1'b0, ~w, ~t, ~r, ~g, ~id, ~c};
    @(posedge CLK);
    gr = ACC_GRANT;
    dn = ACC_DENY;
  endtask
endmodule // bus_initiator_model

// [verification/bus_target_permission_log_tb_top.sv]
// self-checking bench for the bus target permission log block
module bus_target_permission_log_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK, NRST, PSEL, PENABLE, PWRITE, err, gr, dn;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, rd;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, ACC_VALID, ACC_WRITE, ACC_GRANT, ACC_DENY, IRQ;
  wire  [3:0]  ACC_TARGET, ACC_REGION;
  wire  [1:0]  ACC_GROUP;
  wire  [7:0]  ACC_ID;
  wire  [2:0]  ACC_CMD;
  int          failures, tests_run;
  bus_target_permission_log dut_u (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .ACC_VALID, .ACC_WRITE, .ACC_TARGET, .ACC_REGION,
    .ACC_GROUP, .ACC_ID, .ACC_CMD, .ACC_GRANT, .ACC_DENY, .IRQ);
  bus_initiator_model init_u (.CLK, .ACC_VALID, .ACC_WRITE, .ACC_TARGET, .ACC_REGION,
    .ACC_GROUP, .ACC_ID, .ACC_CMD, .ACC_GRANT, .ACC_DENY);
  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      failures++;
      tally_and_finish;
    end
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic s_perm;
    apb(1'b0, 12'h444, 32'h0);
    check("perm reset", 32'h7, rd);
    apb(1'b1, 12'h48c, 32'hffff_fff0);
    apb(1'b0, 12'h48c, 32'h0);
    check("perm upper", 32'h0, rd);
    apb(1'b1, 12'h480, 32'h0);
    apb(1'b0, 12'h480, 32'h0);
    check("perm preset", 32'h1, rd);
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, 12'h48c, 32'h1 << g);
      for (int k = 0; k < 4; k++) begin
        init_u.access(1'b1, 4'h2, 4'h3, k[1:0], 8'h11, 3'h1, gr, dn);
        check("grant deny", {30'h0, k == g, k != g}, {30'h0, gr, dn});
      end
    end
    apb(1'b0, 12'h040, 32'h0);
    check("status t2", 32'h4, rd);
  endtask
  task automatic s_log;
    apb(1'b0, 12'h034, 32'h0);
    check("log reset", 32'h0, rd);
    apb(1'b1, 12'h044, 32'h20);
    init_u.access(1'b1, 4'h5, 4'h4, 2'h3, 8'ha5, 3'h5, gr, dn);
    check("deny irq", 32'h3, {30'h0, dn, IRQ});
    apb(1'b0, 12'h014, 32'h0);
    check("first log", 32'h0300_a545, rd);
    init_u.access(1'b1, 4'h5, 4'h4, 2'h3, 8'h3c, 3'h2, gr, dn);
    apb(1'b0, 12'h014, 32'h0);
    check("multi log", 32'h8300_a545, rd);
    apb(1'b0, 12'h040, 32'h0);
    check("status t5", 32'h20, rd);
    apb(1'b0, 12'h040, 32'h0);
    check("status clr irq", 32'h0, {rd[30:0], IRQ});
    apb(1'b1, 12'h014, 32'h8f00_0000);
    apb(1'b0, 12'h014, 32'h0);
    check("log clr", 32'h0, rd & 32'hff00_0000);
    apb(1'b1, 12'h044, 32'h0);
    init_u.access(1'b1, 4'h5, 4'h4, 2'h3, 8'h3c, 3'h2, gr, dn);
    check("irq masked", 32'h0, {31'h0, IRQ});
    apb(1'b0, 12'h014, 32'h0);
    check("new capture", 32'h0300_3c42, rd);
    apb(1'b1, 12'h044, 32'h20);
    apb(1'b0, 12'h044, 32'h0);
    check("mask irq", 32'h41, {rd[30:0], IRQ});
  endtask
  task automatic s_misc;
    apb(1'b0, 12'h048, 32'h0);
    check("unmapped", 32'h1, {rd[30:0], err});
    init_u.access(1'b0, 4'h5, 4'h4, 2'h3, 8'h01, 3'h0, gr, dn);
    check("read grant", 32'h2, {30'h0, gr, dn});
    init_u.access(1'b1, 4'he, 4'h4, 2'h3, 8'h01, 3'h0, gr, dn);
    check("far target", 32'h2, {30'h0, gr, dn});
  endtask
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    failures = 0;
    tests_run = 0;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    s_perm;
    s_log;
    s_misc;
    tally_and_finish;
  end
endmodule // bus_target_permission_log_tb_top
